/* pcmse_pkg.sv */
// constants, types and line-code encodings for the serial bit stream encoder
package pcmse_pkg;
   localparam int unsigned CLK_HZ          = 200_000_000;
   localparam int unsigned MIN_BPS         = 10;
   localparam int unsigned CLASS1_MAX_BPS  = 5_000_000;
   localparam int unsigned HALF_W          = 24;
   // half-bit counts in sys_clk cycles; integer division keeps the rate exact
   localparam logic [HALF_W-1:0] HALF_MAX        = HALF_W'(CLK_HZ / (2 * MIN_BPS));
   localparam logic [HALF_W-1:0] HALF_MIN_CLASS1 = HALF_W'(CLK_HZ / (2 * CLASS1_MAX_BPS));
   localparam logic [HALF_W-1:0] HALF_MIN_ABS    = 24'h000001;
   localparam int unsigned WORD_W          = 64;
   localparam int unsigned LEN_W           = 7;
   localparam logic [LEN_W-1:0] LEN_MIN        = 7'h04;
   localparam logic [LEN_W-1:0] LEN_MAX_CLASS1 = 7'h10;
   localparam logic [LEN_W-1:0] LEN_MAX_CLASS2 = 7'h40;
   localparam int unsigned FBITS_W         = 15;
   localparam int unsigned FWORDS_W        = 11;
   localparam logic [FBITS_W-1:0]  FRAME_BITS_CLASS1  = 15'h2000;
   localparam logic [FBITS_W-1:0]  FRAME_BITS_CLASS2  = 15'h4000;
   localparam logic [FWORDS_W-1:0] FRAME_WORDS_CLASS1 = 11'h400;
   localparam logic [14:0] LFSR_SEED = 15'h7FFF;
   localparam logic        LINE_IDLE = 1'h0;

   typedef enum logic [2:0] {
      PCMSE_LEVEL_NRZ                   = 3'h0,
      PCMSE_MARK_NRZ                    = 3'h1,
      PCMSE_SPACE_NRZ                   = 3'h2,
      PCMSE_LEVEL_BIPHASE               = 3'h3,
      PCMSE_MARK_BIPHASE                = 3'h4,
      PCMSE_SPACE_BIPHASE               = 3'h5,
      PCMSE_RANDOMIZED_LEVEL_NONRETURN  = 3'h6
   } pcmse_code_t;

   typedef enum logic [0:0] {
      PCMSE_IDLE = 1'h0,
      PCMSE_RUN  = 1'h1
   } pcmse_state_t;

   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic [LEN_W-1:0]  len;
      logic              frameStart;
   } pcmse_entry_t;
endpackage

/* pcmse_word_if.sv */
// word carrier between the buffer and the serializer
interface pcmse_word_if;
   import pcmse_pkg::*;
   logic         valid;
   logic         ready;
   pcmse_entry_t entry;
   modport src (output valid, output entry, input ready);
   modport snk (input valid, input entry, output ready);
endinterface

/* pcmse_buf.sv */
// two-entry word buffer between the user port and the serializer
module pcmse_buf
   import pcmse_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic         fillValid,
   output logic              fillReady,
   input  wire pcmse_entry_t fillEntry,
   pcmse_word_if.src         drain
);
   typedef struct packed {
      pcmse_entry_t [1:0] slot;
      logic               wrPtr;
      logic               rdPtr;
      logic [1:0]         count;
      logic               notFull;
   } pcmse_buf_state_t;

   pcmse_buf_state_t s_reg, s_next;
   logic             push;
   logic             pop;

   // ready comes from a flop so the top output is registered
   assign fillReady   = s_reg.notFull;
   assign drain.valid = (s_reg.count != 2'h0);
   assign drain.entry = s_reg.slot[s_reg.rdPtr];

   // pointer and count update; a full buffer stalls the filling side
   always_comb begin
      push   = fillValid && s_reg.notFull;
      pop    = drain.valid && drain.ready;
      s_next = s_reg;
      if (push) begin
         s_next.slot[s_reg.wrPtr] = fillEntry;
         s_next.wrPtr             = ~s_reg.wrPtr;
      end
      if (pop) begin
         s_next.rdPtr = ~s_reg.rdPtr;
      end
      s_next.count   = s_reg.count + 2'(push) - 2'(pop);
      s_next.notFull = (s_next.count != 2'h2);
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '{slot: '0, wrPtr: 1'h0, rdPtr: 1'h0, count: 2'h0, notFull: 1'h1};
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

/* pcmse_top.sv */
// serial PCM bit stream encoder: serializer, line coder, class limits
module pcmse_top
   import pcmse_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic              enable,
   input  wire logic [2:0]        cfgCode,
   input  wire logic              cfgClass2,
   input  wire logic [HALF_W-1:0] cfgHalfPeriod,
   input  wire logic              inValid,
   output logic                   inReady,
   input  wire logic [WORD_W-1:0] inWord,
   input  wire logic [LEN_W-1:0]  inLen,
   input  wire logic              inFrameStart,
   output logic                   lineOut,
   output logic                   lineActive,
   output logic                   bitStart,
   output logic                   cfgError,
   output logic                   lenError,
   output logic                   frameError
);
   typedef struct packed {
      pcmse_state_t      st;
      pcmse_code_t       code;
      logic              class2;
      logic [HALF_W-1:0] half;
      logic [HALF_W-1:0] halfCnt;
      logic              secondHalf;
      logic              level;
      logic              line;
      logic [14:0]       lfsr;
      logic [WORD_W-1:0] sh;
      logic [LEN_W-1:0]  bitsLeft;
      logic              fillTgl;
      logic [FBITS_W-1:0]  frameBits;
      logic [FWORDS_W-1:0] frameWords;
      logic              bitPulse;
      logic              cfgErr;
      logic              lenErr;
      logic              frameErr;
   } pcmse_top_state_t;

   pcmse_top_state_t s_reg, s_next;
   pcmse_word_if     wordBus ();
   pcmse_entry_t     inEntry;
   logic             popNow;
   logic             dataBit;
   logic             newLevel;
   logic [WORD_W-1:0] aligned;

   // legal configuration: rate floor, class one rate ceiling, known code
   function automatic logic cfgBad(input logic [HALF_W-1:0] half,
                                   input logic              cls2,
                                   input logic [2:0]        code);
      logic bad;
      bad = 1'h0;
      if (half > HALF_MAX) bad = 1'h1;
      if (half < HALF_MIN_ABS) bad = 1'h1;
      if (!cls2 && (half < HALF_MIN_CLASS1)) bad = 1'h1;
      if (code > 3'h6) bad = 1'h1;
      return bad;
   endfunction

   // word length window depends on the class
   function automatic logic lenBad(input logic [LEN_W-1:0] len, input logic cls2);
      logic bad;
      bad = (len < LEN_MIN);
      if (!cls2 && (len > LEN_MAX_CLASS1)) bad = 1'h1;
      if (cls2 && (len > LEN_MAX_CLASS2)) bad = 1'h1;
      return bad;
   endfunction

   assign inEntry = '{word: inWord, len: inLen, frameStart: inFrameStart};

   pcmse_buf u_buf (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .fillValid (inValid),
      .fillReady (inReady),
      .fillEntry (inEntry),
      .drain     (wordBus.src)
   );

   // every top output is a straight copy of a state flop
   assign wordBus.ready = popNow;
   assign lineOut       = s_reg.line;
   assign lineActive    = (s_reg.st == PCMSE_RUN);
   assign bitStart      = s_reg.bitPulse;
   assign cfgError      = s_reg.cfgErr;
   assign lenError      = s_reg.lenErr;
   assign frameError    = s_reg.frameErr;

   // sequencing, bit selection and line coding all in one next-state pass
   always_comb begin
      s_next   = s_reg;
      popNow   = 1'h0;
      dataBit  = 1'h0;
      newLevel = s_reg.level;
      aligned  = '0;
      // pulse and pin check are recomputed every cycle, not held
      s_next.bitPulse = 1'h0;
      s_next.cfgErr   = cfgBad(cfgHalfPeriod, cfgClass2, cfgCode);
      case (s_reg.st)
         PCMSE_IDLE: begin
            // line rests at its idle level between streams
            s_next.line = LINE_IDLE;
            if (enable && !s_next.cfgErr) begin
               // config is captured once; later pin changes are ignored
               s_next.st         = PCMSE_RUN;
               s_next.code       = pcmse_code_t'(cfgCode);
               s_next.class2     = cfgClass2;
               s_next.half       = cfgHalfPeriod;
               s_next.halfCnt    = '0;
               s_next.secondHalf = 1'h1;
               s_next.level      = 1'h0;
               s_next.lfsr       = LFSR_SEED;
               s_next.bitsLeft   = '0;
               s_next.fillTgl    = 1'h0;
               s_next.frameBits  = '0;
               s_next.frameWords = '0;
               s_next.lenErr     = 1'h0;
               s_next.frameErr   = 1'h0;
            end
         end
         PCMSE_RUN: begin
            // half-bit timer; both halves get the same count
            s_next.halfCnt = s_reg.halfCnt - 1'h1;
            if (s_reg.halfCnt == '0) begin
               // exact divider from sys_clk: no drift, no jitter at the bit edges
               s_next.halfCnt = s_reg.half - 1'h1;
               if (!s_reg.secondHalf) begin
                  s_next.secondHalf = 1'h1;
                  if (s_reg.code == PCMSE_LEVEL_BIPHASE || s_reg.code == PCMSE_MARK_BIPHASE ||
                      s_reg.code == PCMSE_SPACE_BIPHASE) begin
                     s_next.line = ~s_reg.level;
                  end
               end else if (!enable) begin
                  // stop only on a bit boundary so no bit is cut short
                  s_next.st   = PCMSE_IDLE;
                  s_next.line = LINE_IDLE;
               end else begin
                  s_next.secondHalf = 1'h0;
                  s_next.bitPulse   = 1'h1;
                  if (s_reg.bitsLeft != '0) begin
                     dataBit          = s_reg.sh[WORD_W-1];
                     s_next.sh        = {s_reg.sh[WORD_W-2:0], 1'h0};
                     s_next.bitsLeft  = s_reg.bitsLeft - 1'h1;
                  end else if (wordBus.valid) begin
                     popNow = 1'h1;
                     if (lenBad(wordBus.entry.len, s_reg.class2)) begin
                        // rejected word is dropped; a fill bit keeps the stream going
                        s_next.lenErr  = 1'h1;
                        dataBit        = s_reg.fillTgl;
                        s_next.fillTgl = ~s_reg.fillTgl;
                     end else begin
                        aligned         = wordBus.entry.word <<
                                          (7'(WORD_W) - wordBus.entry.len);
                        dataBit         = aligned[WORD_W-1];
                        s_next.sh       = {aligned[WORD_W-2:0], 1'h0};
                        s_next.bitsLeft = wordBus.entry.len - 1'h1;
                        if (wordBus.entry.frameStart) begin
                           s_next.frameBits  = '0;
                           s_next.frameWords = 11'h001;
                        end else if (s_reg.frameWords != '1) begin
                           s_next.frameWords = s_reg.frameWords + 1'h1;
                        end
                     end
                  end else begin
                     // underrun: alternating fill keeps transitions and no gaps
                     dataBit        = s_reg.fillTgl;
                     s_next.fillTgl = ~s_reg.fillTgl;
                  end
                  // saturate instead of wrapping so a runaway frame stays flagged
                  if (s_next.frameBits != '1) begin
                     s_next.frameBits = s_next.frameBits + 1'h1;
                  end
                  // limits judged on the bit just counted; flags stay until restart
                  if (!s_reg.class2 && ((s_next.frameBits > FRAME_BITS_CLASS1) ||
                      (s_next.frameWords > FRAME_WORDS_CLASS1))) begin
                     s_next.frameErr = 1'h1;
                  end
                  if (s_reg.class2 && (s_next.frameBits > FRAME_BITS_CLASS2)) begin
                     s_next.frameErr = 1'h1;
                  end
                  // differential codes fold in the previous level
                  case (s_reg.code)
                     PCMSE_MARK_NRZ, PCMSE_MARK_BIPHASE:
                        newLevel = s_reg.level ^ dataBit;
                     PCMSE_SPACE_NRZ, PCMSE_SPACE_BIPHASE:
                        newLevel = s_reg.level ^ ~dataBit;
                     PCMSE_RANDOMIZED_LEVEL_NONRETURN: begin
                        // self-synchronising scrambler, taps at stages 14 and 15
                        newLevel    = dataBit ^ s_reg.lfsr[13] ^ s_reg.lfsr[14];
                        s_next.lfsr = {s_reg.lfsr[13:0], newLevel};
                     end
                     default:
                        newLevel = dataBit;
                  endcase
                  s_next.level = newLevel;
                  s_next.line  = newLevel;
               end
            end
         end
         default: begin
            s_next.st   = PCMSE_IDLE;
            s_next.line = LINE_IDLE;
         end
      endcase
   end

   // reset idles the line, clears the differential level and reseeds
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_reg      <= '0;
         s_reg.lfsr <= LFSR_SEED;
         s_reg.line <= LINE_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

/* pcmse_top_sva.sv */
// assertions on the encoder pins, bound to pcmse_top
module pcmse_top_sva
   import pcmse_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              resetn,
   input wire logic [2:0]        cfgCode,
   input wire logic              cfgClass2,
   input wire logic [HALF_W-1:0] cfgHalfPeriod,
   input wire logic              lineOut,
   input wire logic              lineActive,
   input wire logic              bitStart,
   input wire logic              cfgError,
   input wire logic              lenError,
   input wire logic              frameError
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [HALF_W:0]   cnt;
   logic [HALF_W:0]   twoH;
   logic [HALF_W-1:0] hLat;
   logic [2:0]        cLat;
   logic              gotOne;
   logic              firstLvl;
   logic              biph;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // settings latched while idle, since pins may move mid-stream
   assign biph = cLat inside {3'h3, 3'h4, 3'h5};
   assign twoH = {hLat, 1'b0};
   // cycles since the last bit start and the bit's first level
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt      <= '0;
         hLat     <= '0;
         cLat     <= 3'h0;
         gotOne   <= 1'b0;
         firstLvl <= 1'b0;
      end else begin
         cnt <= bitStart ? 25'h0000001 : cnt + 25'h0000001;
         if (!lineActive) begin
            hLat   <= cfgHalfPeriod;
            cLat   <= cfgCode;
            gotOne <= 1'b0;
         end else if (bitStart) begin
            gotOne   <= 1'b1;
            firstLvl <= lineOut;
         end
      end
   end
   property p_idle_low; !lineActive |-> lineOut == LINE_IDLE; endproperty
   a_idle_low: assert property (p_idle_low) else $error("line not idle");
   property p_start; $rose(lineActive) |-> (lineOut == LINE_IDLE && !bitStart) ##1 bitStart;
   endproperty
   a_start: assert property (p_start) else $error("bad start sequence");
   property p_spacing; bitStart && gotOne |-> cnt == twoH; endproperty
   a_spacing: assert property (p_spacing) else $error("bit period wrong");
   property p_gapless; gotOne && lineActive |-> cnt <= twoH; endproperty
   a_gapless: assert property (p_gapless) else $error("gap in stream");
   property p_half_hold; gotOne && lineActive && cnt < hLat |-> lineOut == firstLvl; endproperty
   a_half_hold: assert property (p_half_hold) else $error("first half moved");
   property p_biph_inv;
      gotOne && lineActive && biph && cnt >= hLat && cnt < twoH |-> lineOut != firstLvl;
   endproperty
   a_biph_inv: assert property (p_biph_inv) else $error("second half not inverted");
   property p_nrz_hold; gotOne && lineActive && !biph && cnt < twoH |-> lineOut == firstLvl;
   endproperty
   a_nrz_hold: assert property (p_nrz_hold) else $error("level moved in bit");
   property p_bad_code; cfgCode == 3'h7 |=> cfgError; endproperty
   a_bad_code: assert property (p_bad_code) else $error("illegal code accepted");
   property p_slow; cfgHalfPeriod > HALF_MAX |=> cfgError; endproperty
   a_slow: assert property (p_slow) else $error("rate below minimum accepted");
   property p_class1; !cfgClass2 && cfgHalfPeriod < HALF_MIN_CLASS1 |=> cfgError; endproperty
   a_class1: assert property (p_class1) else $error("fast rate in class one");
   property p_refuse; !lineActive && cfgCode == 3'h7 |=> !lineActive; endproperty
   a_refuse: assert property (p_refuse) else $error("started on illegal code");
   c_biph: cover property (bitStart && biph);
   c_len: cover property ($rose(lenError));
   c_cfg: cover property ($rose(cfgError));
   c_frame: cover property ($rose(frameError));
endmodule
bind pcmse_top pcmse_top_sva u_sva (.sys_clk(sys_clk), .resetn(resetn), .cfgCode(cfgCode),
   .cfgClass2(cfgClass2), .cfgHalfPeriod(cfgHalfPeriod), .lineOut(lineOut),
   .lineActive(lineActive), .bitStart(bitStart), .cfgError(cfgError), .lenError(lenError),
   .frameError(frameError));

/* pcmse_rx_model.sv */
// far-end bit synchronizer: decodes the line back to data bits
module pcmse_rx_model
   import pcmse_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic              lineOut,
   input  wire logic              lineActive,
   input  wire logic              bitStart,
   input  wire logic [2:0]        cfgCode,
   input  wire logic [HALF_W-1:0] cfgHalfPeriod,
   output logic                   rxBit,
   output logic                   rxValid,
   output logic                   rxBad
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0]        code;
   logic [HALF_W-1:0] half;
   logic [HALF_W-1:0] cnt;
   logic [14:0]       seed;
   logic              prevLvl;
   logic              firstLvl;
   logic              biph;
   assign biph = code inside {3'h3, 3'h4, 3'h5};
   // second sample at mid-bit; rxBad is sticky so a single bad bit is not lost
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         {rxBit, rxValid, rxBad, prevLvl, firstLvl} <= 5'h00;
         code <= 3'h0;
         half <= '0;
         cnt  <= '0;
         seed <= LFSR_SEED;
      end else begin
         rxValid <= 1'b0;
         cnt     <= cnt + 24'h000001;
         if (!lineActive) begin
            code    <= cfgCode;
            half    <= cfgHalfPeriod;
            prevLvl <= 1'b0;
            seed    <= LFSR_SEED;
            cnt     <= '0;
         end else if (bitStart) begin
            firstLvl <= lineOut;
            cnt      <= 24'h000001;
         end else if (cnt == half) begin
            rxBad   <= rxBad | (biph ? lineOut == firstLvl : lineOut != firstLvl);
            rxValid <= 1'b1;
            prevLvl <= firstLvl;
            seed    <= {seed[13:0], firstLvl};
            case (code)
               3'h0, 3'h3: rxBit <= firstLvl;
               3'h1, 3'h4: rxBit <= firstLvl ^ prevLvl;
               3'h2, 3'h5: rxBit <= ~(firstLvl ^ prevLvl);
               default:    rxBit <= firstLvl ^ seed[13] ^ seed[14];
            endcase
         end
      end
   end
endmodule

/* test_pcm_serial_bit_stream_encoder.sv */
// self-checking bench for the serial bit stream encoder
module test_pcm_serial_bit_stream_encoder;
   import pcmse_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic              sys_clk = 1'b0;
   logic              resetn = 1'b0;
   logic              enable = 1'b0;
   logic [2:0]        cfgCode = 3'h0;
   logic              cfgClass2 = 1'b1;
   logic [HALF_W-1:0] cfgHalfPeriod = 24'h000006;
   logic              inValid = 1'b0;
   logic [WORD_W-1:0] inWord = 64'h0;
   logic [LEN_W-1:0]  inLen = 7'h10;
   logic              frameStart = 1'h0;
   logic              inReady, lineOut, lineActive, bitStart, cfgError, lenError, frameError;
   logic              rxBit, rxValid, rxBad;
   int                badCount = 0;
   int                checked = 0;
   int                cycles = 0;
   always #2.5 sys_clk = ~sys_clk;
   pcmse_top DUT (.sys_clk(sys_clk), .resetn(resetn), .enable(enable), .cfgCode(cfgCode),
      .cfgClass2(cfgClass2), .cfgHalfPeriod(cfgHalfPeriod), .inValid(inValid),
      .inReady(inReady), .inWord(inWord), .inLen(inLen), .inFrameStart(frameStart),
      .lineOut(lineOut), .lineActive(lineActive), .bitStart(bitStart), .cfgError(cfgError),
      .lenError(lenError), .frameError(frameError));
   pcmse_rx_model rx (.sys_clk(sys_clk), .resetn(resetn), .lineOut(lineOut),
      .lineActive(lineActive), .bitStart(bitStart), .cfgCode(cfgCode),
      .cfgHalfPeriod(cfgHalfPeriod), .rxBit(rxBit), .rxValid(rxValid), .rxBad(rxBad));
   task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         badCount++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task giveVerdict;
      $display("checks %0d mismatches %0d", checked, badCount);
      if (badCount == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hold the word until a cycle where the buffer shows room
   task push(input logic [63:0] w, input logic [6:0] l);
      @(posedge sys_clk);
      inValid <= 1'b1;
      inWord  <= w;
      inLen   <= l;
      do @(negedge sys_clk); while (inReady !== 1'b1);
      @(posedge sys_clk);
      inValid <= 1'b0;
   endtask
   task grab(input int n, output logic [63:0] bits);
      bits = '0;
      repeat (n) begin
         do @(negedge sys_clk); while (rxValid !== 1'b1);
         bits = {bits[62:0], rxBit};
      end
   endtask
   task stop;
      @(posedge sys_clk);
      enable <= 1'b0;
      do @(negedge sys_clk); while (lineActive !== 1'b0);
   endtask
   // three words per code, first two fill the buffer, third held on the port until one is drained
   task run_code(input logic [2:0] code);
      logic [63:0] got;
      @(posedge sys_clk);
      cfgCode       <= code;
      cfgClass2     <= 1'b1;
      cfgHalfPeriod <= 24'h000006;
      push(64'hA5C3, 7'h10);
      push(64'h3C96, 7'h10);
      repeat (2) @(negedge sys_clk);
      check("inReady full", {63'h0, inReady}, 64'h0);
      @(posedge sys_clk);
      enable <= 1'b1;
      @(posedge sys_clk);
      cfgCode       <= code ^ 3'h1;
      cfgHalfPeriod <= 24'h000005;
      push(64'h0F71, 7'h10);
      grab(48, got);
      check("decoded bits", got, 64'h0000A5C33C960F71);
      check("half levels", {63'h0, rxBad}, 64'h0);
      stop;
      check("idle line", {63'h0, lineOut}, 64'h0);
      $display("code %0d done", code);
   endtask
   task len_case(input logic cls, input logic [6:0] len, input logic exp);
      @(posedge sys_clk);
      cfgClass2     <= cls;
      cfgCode       <= 3'h0;
      cfgHalfPeriod <= 24'h000014;
      push(64'h9, len);
      @(posedge sys_clk);
      enable <= 1'b1;
      repeat (120) @(negedge sys_clk);
      check("lenError", {63'h0, lenError}, {63'h0, exp});
      stop;
      $display("length %0d done", len);
   endtask
   // illegal settings must flag and must not start
   task cfg_case(input logic [2:0] code, input logic cls, input logic [23:0] h, input logic exp);
      @(posedge sys_clk);
      cfgCode       <= code;
      cfgClass2     <= cls;
      cfgHalfPeriod <= h;
      enable        <= exp;
      repeat (3) @(negedge sys_clk);
      check("cfgError", {63'h0, cfgError}, {63'h0, exp});
      check("refused start", {63'h0, lineActive}, 64'h0);
      stop;
      $display("setting %0d %0d %0h done", code, cls, h);
   endtask
   // reset in mid-stream must idle the line at once
   task reset_case;
      @(posedge sys_clk);
      cfgCode       <= 3'h6;
      cfgClass2     <= 1'h1;
      cfgHalfPeriod <= 24'h000003;
      enable        <= 1'h1;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'h0;
      enable <= 1'h0;
      repeat (2) @(negedge sys_clk);
      check("mid reset line", {62'h0, lineOut, lineActive}, 64'h0);
      check("mid reset ready", {63'h0, inReady}, 64'h1);
      @(posedge sys_clk);
      resetn <= 1'h1;
      repeat (2) @(negedge sys_clk);
      check("after reset line", {62'h0, lineOut, lineActive}, 64'h0);
      $display("mid-run reset done");
   endtask
   // one long class two frame: the bit after 16384 must raise the flag
   task frame_case;
      @(posedge sys_clk);
      cfgClass2     <= 1'h1;
      cfgCode       <= 3'h0;
      cfgHalfPeriod <= 24'h000001;
      frameStart    <= 1'h1;
      push(64'hF0F0, 7'h10);
      frameStart <= 1'h0;
      @(posedge sys_clk);
      enable <= 1'h1;
      do @(negedge sys_clk); while (bitStart !== 1'h1);
      repeat (16383) do @(negedge sys_clk); while (bitStart !== 1'h1);
      check("frameError at limit", {63'h0, frameError}, 64'h0);
      do @(negedge sys_clk); while (bitStart !== 1'h1);
      check("frameError past limit", {63'h0, frameError}, 64'h1);
      stop;
      $display("frame limit done");
   endtask
   // hang guard: the whole sequence needs well under this many cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         badCount++;
         giveVerdict;
      end
   end
   initial begin
      repeat (4) @(negedge sys_clk);
      check("reset line", {62'h0, lineOut, lineActive}, 64'h0);
      check("reset ready", {63'h0, inReady}, 64'h1);
      @(posedge sys_clk);
      resetn <= 1'b1;
      for (int c = 0; c < 7; c++) run_code(3'(c));
      reset_case;
      len_case(1'b0, 7'h11, 1'b1);
      len_case(1'b1, 7'h03, 1'b1);
      len_case(1'b0, 7'h10, 1'b0);
      cfg_case(3'h7, 1'b1, 24'h000006, 1'b1);
      cfg_case(3'h0, 1'b0, 24'h000013, 1'b1);
      cfg_case(3'h0, 1'b0, 24'h000014, 1'b0);
      cfg_case(3'h0, 1'b1, 24'h000000, 1'b1);
      cfg_case(3'h0, 1'b1, HALF_MAX + 24'h000001, 1'b1);
      cfg_case(3'h0, 1'b1, HALF_MAX, 1'b0);
      frame_case;
      giveVerdict;
   end
endmodule
